// ---- hdl/lsd_regs.sv ----
// SPI register bank, fault status and duty modulators of the low-side drivers.
// Summary of operation
// - Low seven duty bits set on-time in one percent steps, 0 to 100.
// - Duty codes from 100 to 127 all mean full on, never wrap.
// - Duty registers at 2,4,5,6,7; location 3 and bit 7 unused; reset zero.
// - Fault registers at 0,2,3,4,5; location 1 unused; all reset zero.
// - Fault bit 7 is the OR of the same register's bits 0 to 3.
// - Bit 3 flags open load and reads zero when detection is off.
// - Bit 2 flags overcurrent, bit 1 flags overtemperature, else zero.
// - Bit 0 flags short to ground, absent on the tachometer driver.
// - Location 14 shows on states of injector, relays, lamp, pre-drivers.
// - Spark pre-driver follows its parallel input; floating means off.
// - Heater pre-driver follows its parallel input; floating means off.
// - Internal modulation runs at 100 Hz or 1 kHz; other settings give none.
// - A cleared open-load sink enable forces that open-load flag to zero.
`timescale 1ns/1ps
`include "lsd_cfg.svh"

module lsd_regs #(
  parameter int SLOW_STEP_CYC = `LSD_SLOW_STEP_CYC
) (
  input  wire logic        clk_in,                // 100 MHz clock
  input  wire logic        reset_in,              // Synchronous, active high
  input  wire logic        spi_sclk_in,           // Serial clock
  input  wire logic        spi_cs_n_in,           // Chip select, active low
  input  wire logic        spi_mosi_in,           // Serial data in
  output logic             spi_miso_out,          // Serial data out
  input  wire logic [4:0]  drv_on_cmd_in,         // Per-driver on command
  input  wire logic [9:0]  pwm_rate_sel_in,       // Two rate bits per driver
  input  wire logic [4:0]  ol_sink_en_in,         // Open-load sink enables
  input  wire logic [4:0]  open_load_in,          // Raw open-load detect
  input  wire logic [4:0]  overcurrent_in,        // Raw overcurrent detect
  input  wire logic [4:0]  overtemp_in,           // Raw overtemp detect
  input  wire logic [4:0]  short_gnd_in,          // Raw short-to-ground
  input  wire logic        spark_parallel_in,     // Spark pre-driver input
  input  wire logic        heater_parallel_in,    // Heater pre-driver input
  output logic [4:0]       driver_gate_out,       // Low-side driver gates
  output logic             spark_gate_out,        // Spark pre-driver gate
  output logic             heater_gate_out        // Heater pre-driver gate
);

  localparam int FAST_STEP_CYC = `LSD_FAST_STEP_CYC;
  localparam logic [9:0]  FAST_LAST = 10'(FAST_STEP_CYC - 1);
  localparam logic [15:0] SLOW_LAST = 16'(SLOW_STEP_CYC - 1);

  lsd_pkg::lsd_spi_state_t state_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  rx_ff;
  logic [7:0]  hdr_ff;
  logic [7:0]  tx_ff;
  logic        sclk_d_ff;
  logic        cs_n_d_ff;
  logic [9:0]  fast_cnt_ff;
  logic [15:0] slow_cnt_ff;
  logic [6:0]  duty_ff  [5];
  logic [3:0]  fault_ff [5];
  logic [6:0]  phase_ff [5];
  logic [7:0]  ind_ff;

  // Returns {hit, index} of the driver whose register sits at addr.
  function automatic logic [3:0] drv_decode(input logic stat,
                                            input logic [5:0] addr);
    logic [3:0] res;
    res = 4'h0;
    if (stat) begin
      unique case (addr)
        `LSD_ADDR_FLT_INJ:  res = 4'h8;
        `LSD_ADDR_FLT_RELAY_ONE_ON_STATE: res = 4'h9;
        `LSD_ADDR_FLT_RELAY_TWO_ON_STATE: res = 4'hA;
        `LSD_ADDR_FLT_TACH: res = 4'hB;
        `LSD_ADDR_FLT_LAMP: res = 4'hC;
        default:            res = 4'h0;
      endcase
    end else begin
      unique case (addr)
        `LSD_ADDR_DUTY_INJ:  res = 4'h8;
        `LSD_ADDR_DUTY_RELAY_ONE_ON_STATE: res = 4'h9;
        `LSD_ADDR_DUTY_RELAY_TWO_ON_STATE: res = 4'hA;
        `LSD_ADDR_DUTY_TACH: res = 4'hB;
        `LSD_ADDR_DUTY_LAMP: res = 4'hC;
        default:             res = 4'h0;
      endcase
    end
    return res;
  endfunction

  // Serial front end: SCLK is sampled by clk_in, so it must run well below it.
  wire       sclk_rise   = spi_sclk_in & ~sclk_d_ff;
  wire       sclk_fall   = ~spi_sclk_in & sclk_d_ff;
  wire       frame_start = cs_n_d_ff & ~spi_cs_n_in;
  wire       byte_done   = sclk_rise & (bit_cnt_ff == 3'h7);
  wire [7:0] shift_in    = {rx_ff[6:0], spi_mosi_in};

  // Read decode works on the header as it completes.
  // Decoding on the fly costs a wide path behind the eighth rise, but the
  // read byte is then ready before the first falling edge of the data byte.
  wire       rd_stat = shift_in[`LSD_HDR_STATUS_BIT];
  wire [3:0] rd_dec  = drv_decode(rd_stat, shift_in[5:0]);
  wire [2:0] rd_idx  = rd_dec[2:0];
  wire       rd_ind  = rd_stat & (shift_in[5:0] == `LSD_ADDR_ON_IND);
  wire [7:0] rd_flt  = {|fault_ff[rd_idx], 3'h0, fault_ff[rd_idx]};
  wire [7:0] rd_duty = {1'b0, duty_ff[rd_idx]};
  wire [7:0] rd_data = rd_ind ? ind_ff :
                       !rd_dec[3] ? `LSD_REG_RESET :
                       rd_stat ? rd_flt : rd_duty;

  // Write decode uses the latched header; only the control bank is writable.
  wire [3:0] wr_dec  = drv_decode(hdr_ff[`LSD_HDR_STATUS_BIT], hdr_ff[5:0]);
  wire       wr_fire = (state_ff == lsd_pkg::LSD_SPI_DATA) & byte_done &
                       hdr_ff[`LSD_HDR_WRITE_BIT] &
                       ~hdr_ff[`LSD_HDR_STATUS_BIT] & wr_dec[3];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= spi_sclk_in;
      cs_n_d_ff <= spi_cs_n_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || spi_cs_n_in) begin
      state_ff     <= lsd_pkg::LSD_SPI_IDLE;
      bit_cnt_ff   <= 3'h0;
      spi_miso_out <= 1'b0;
      if (reset_in) begin
        rx_ff  <= 8'h00;
        hdr_ff <= 8'h00;
        tx_ff  <= 8'h00;
      end
    end else begin
      if (sclk_rise && state_ff != lsd_pkg::LSD_SPI_IDLE) begin
        rx_ff      <= shift_in;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      unique case (state_ff)
        lsd_pkg::LSD_SPI_IDLE: begin
          if (frame_start) begin
            state_ff <= lsd_pkg::LSD_SPI_HDR;
          end
        end
        lsd_pkg::LSD_SPI_HDR: begin
          if (byte_done) begin
            hdr_ff   <= shift_in;
            tx_ff    <= rd_data;
            state_ff <= lsd_pkg::LSD_SPI_DATA;
          end
        end
        lsd_pkg::LSD_SPI_DATA: begin
          if (sclk_fall) begin
            spi_miso_out <= tx_ff[7];
            tx_ff        <= {tx_ff[6:0], 1'b0};
          end
          // Extra clocks after the second byte are ignored until CS rises.
          if (byte_done) begin
            state_ff <= lsd_pkg::LSD_SPI_IDLE;
          end
        end
        default: state_ff <= lsd_pkg::LSD_SPI_IDLE;
      endcase
    end
  end

  // Shared step ticks for both modulation rates.
  // Sharing one divider keeps drivers of equal rate in phase with each other.
  wire tick_fast = (fast_cnt_ff == FAST_LAST);
  wire tick_slow = (slow_cnt_ff == SLOW_LAST);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fast_cnt_ff <= 10'h000;
      slow_cnt_ff <= 16'h0000;
    end else begin
      fast_cnt_ff <= tick_fast ? 10'h000 : fast_cnt_ff + 10'h001;
      slow_cnt_ff <= tick_slow ? 16'h0000 : slow_cnt_ff + 16'h0001;
    end
  end

  logic [4:0] gate_ff;
  logic [4:0] step_tick;
  logic [4:0] mod_active;
  logic [6:0] duty_sat [5];

  for (genvar i = 0; i < 5; i++) begin : g_drv
    wire lsd_pkg::lsd_rate_t rate =
      lsd_pkg::lsd_rate_t'(pwm_rate_sel_in[2*i+:2]);
    wire fault_sg = (i == 3) ? 1'b0 : short_gnd_in[i];
    assign mod_active[i] = (rate == lsd_pkg::LSD_RATE_100HZ) ||
                           (rate == lsd_pkg::LSD_RATE_1KHZ);
    assign step_tick[i]  = (rate == lsd_pkg::LSD_RATE_1KHZ) ? tick_fast :
                                                              tick_slow;
    assign duty_sat[i]   = (duty_ff[i] >= `LSD_DUTY_FULL) ?
                           `LSD_DUTY_FULL : duty_ff[i];

    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        duty_ff[i] <= `LSD_DUTY_RESET;
      end else if (wr_fire && wr_dec[2:0] == 3'(i)) begin
        duty_ff[i] <= shift_in[6:0];
      end
    end

    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        fault_ff[i] <= 4'h0;
      end else begin
        fault_ff[i] <= {open_load_in[i] & ol_sink_en_in[i],
                        overcurrent_in[i], overtemp_in[i],
                        fault_sg};
      end
    end

    // Phase counts 0..99; on while below the saturated duty count.
    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        phase_ff[i] <= 7'h00;
        gate_ff[i]  <= 1'b0;
      end else begin
        if (step_tick[i]) begin
          phase_ff[i] <= (phase_ff[i] >= `LSD_LAST_STEP) ? 7'h00 :
                         phase_ff[i] + 7'h01;
        end
        gate_ff[i] <= drv_on_cmd_in[i] &
                      (~mod_active[i] | (phase_ff[i] < duty_sat[i]));
      end
    end
  end

  // Pre-drivers follow their inputs; the pins' pull-downs make floating off.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      spark_gate_out  <= 1'b0;
      heater_gate_out <= 1'b0;
      ind_ff          <= `LSD_REG_RESET;
    end else begin
      spark_gate_out  <= spark_parallel_in;
      heater_gate_out <= heater_parallel_in;
      ind_ff          <= {gate_ff[0], 1'b0, gate_ff[1], gate_ff[2],
                          gate_ff[4], spark_gate_out, 1'b0,
                          heater_gate_out};
    end
  end

  assign driver_gate_out = gate_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_write_done;
    wr_fire && wr_dec[2:0] == 3'h0;
  endsequence

  sequence s_heater_chain;
    heater_gate_out ##1 ind_ff[`LSD_IND_HEATER_BIT];
  endsequence

  sequence s_fault_load;
    !spi_cs_n_in && state_ff == lsd_pkg::LSD_SPI_HDR && byte_done &&
      rd_stat && rd_dec[3];
  endsequence

  AST_DUTY_WRITE: assert property (
    s_write_done |=> duty_ff[0] == $past(shift_in[6:0]))
    else $error("Injector duty write not stored.");
  AST_SUMMARY_OR: assert property (
    overcurrent_in[0] |=> |fault_ff[0])
    else $error("Fault summary missed an overcurrent flag.");
  AST_OL_MASK: assert property (
    !ol_sink_en_in[1] |=> !fault_ff[1][`LSD_FLT_OL_BIT])
    else $error("Open-load flag set with detection off.");
  AST_OC_FLAG: assert property (
    overcurrent_in[2] ##1 1'b1 |-> fault_ff[2][`LSD_FLT_OC_BIT])
    else $error("Overcurrent flag not set.");
  AST_TACH_SG: assert property (
    !fault_ff[3][`LSD_FLT_SG_BIT])
    else $error("Tachometer short-to-ground bit set.");
  AST_SPARK: assert property (
    ##1 spark_gate_out == $past(spark_parallel_in))
    else $error("Spark gate does not follow its input.");
  AST_HEATER: assert property (
    heater_parallel_in |=> s_heater_chain)
    else $error("Heater gate or indicator wrong.");
  AST_IND_INJ: assert property (
    gate_ff[0] |=> ind_ff[`LSD_IND_INJ_BIT])
    else $error("Injector indicator not set.");
  AST_FULL_ON: assert property (
    drv_on_cmd_in[4] && duty_ff[4] >= `LSD_DUTY_FULL |=> gate_ff[4])
    else $error("Saturated duty did not give full on.");
  AST_ZERO_DUTY: assert property (
    mod_active[1] && duty_ff[1] == 7'h00 |=> !gate_ff[1])
    else $error("Zero duty drove the output.");
  AST_FAST_RATE: assert property (
    mod_active[2] && pwm_rate_sel_in[5:4] == 2'h2 && !tick_fast
      |=> $stable(phase_ff[2]))
    else $error("Fast rate phase moved without a step tick.");
  AST_WRAP: assert property (
    phase_ff[3] == `LSD_LAST_STEP && step_tick[3] |=> phase_ff[3] == 7'h00)
    else $error("Phase did not wrap after 100 steps.");
  AST_SUMMARY_READ: assert property (
    s_fault_load |=> tx_ff[7] == |tx_ff[3:0])
    else $error("Fault summary bit disagrees with its flags.");
  AST_STATUS_RO: assert property (
    state_ff == lsd_pkg::LSD_SPI_DATA && byte_done &&
      hdr_ff[`LSD_HDR_STATUS_BIT] |=> $stable(duty_ff[0]))
    else $error("Status bank write changed a duty register.");

endmodule

// ---- include/lsd_cfg.svh ----
// Register map, field positions, reset values and timing counts.
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// Control bank locations of the duty registers.
`define LSD_ADDR_DUTY_INJ      6'h02
`define LSD_ADDR_DUTY_UNUSED   6'h03
`define LSD_ADDR_DUTY_RELAY_ONE_ON_STATE     6'h04
`define LSD_ADDR_DUTY_RELAY_TWO_ON_STATE     6'h05
`define LSD_ADDR_DUTY_TACH     6'h06
`define LSD_ADDR_DUTY_LAMP     6'h07

// Status bank locations.
`define LSD_ADDR_FLT_INJ       6'h00
`define LSD_ADDR_FLT_UNUSED    6'h01
`define LSD_ADDR_FLT_RELAY_ONE_ON_STATE      6'h02
`define LSD_ADDR_FLT_RELAY_TWO_ON_STATE      6'h03
`define LSD_ADDR_FLT_TACH      6'h04
`define LSD_ADDR_FLT_LAMP      6'h05
`define LSD_ADDR_ON_IND        6'h0E

// Frame header byte layout.
`define LSD_HDR_WRITE_BIT      7
`define LSD_HDR_STATUS_BIT     6

// Fault register bit positions.
`define LSD_FLT_SUMMARY_BIT    7
`define LSD_FLT_OL_BIT         3
`define LSD_FLT_OC_BIT         2
`define LSD_FLT_OT_BIT         1
`define LSD_FLT_SG_BIT         0

// Indicator register bit positions.
`define LSD_IND_INJ_BIT        7
`define LSD_IND_RELAY_ONE_ON_STATE_BIT       5
`define LSD_IND_RELAY_TWO_ON_STATE_BIT       4
`define LSD_IND_LAMP_BIT       3
`define LSD_IND_SPARK_BIT      2
`define LSD_IND_HEATER_BIT     0

`define LSD_DUTY_RESET         7'h00
`define LSD_REG_RESET          8'h00
`define LSD_DUTY_FULL          7'h64
`define LSD_LAST_STEP          7'h63

// Modulation timing: each period is split into 100 steps.
`define LSD_CLK_PERIOD_NS      10
`define LSD_STEPS_PER_PERIOD   100
`define LSD_FAST_FREQ_HZ       1000
`define LSD_SLOW_FREQ_HZ       100
`define LSD_FAST_STEP_CYC      (1000000000 / (`LSD_FAST_FREQ_HZ * \
  `LSD_STEPS_PER_PERIOD * `LSD_CLK_PERIOD_NS))
`define LSD_SLOW_STEP_CYC      (1000000000 / (`LSD_SLOW_FREQ_HZ * \
  `LSD_STEPS_PER_PERIOD * `LSD_CLK_PERIOD_NS))

`endif

// ---- include/lsd_pkg.sv ----
// Types shared by the low-side driver register bank.
package lsd_pkg;

  typedef enum logic [2:0] {
    LSD_SPI_IDLE = 3'b001,
    LSD_SPI_HDR  = 3'b010,
    LSD_SPI_DATA = 3'b100
  } lsd_spi_state_t;

  typedef enum logic [1:0] {
    LSD_RATE_NONE  = 2'b00,
    LSD_RATE_100HZ = 2'b01,
    LSD_RATE_1KHZ  = 2'b10,
    LSD_RATE_OFF   = 2'b11
  } lsd_rate_t;

endpackage

// ---- testbench/lsd_spi_host.sv ----
// Host-side SPI master that runs 16-bit register frames in mode 0.
`timescale 1ns/1ps
module lsd_spi_host (
  input  wire logic clk_in,   // Bench clock
  output logic      sclk_out, // Serial clock, idle low
  output logic      cs_n_out, // Chip select, active low
  output logic      mosi_out, // Serial data to the block
  input  wire logic miso_in   // Serial data from the block
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // The high phase lasts four bench clocks and the low phase five, at least four times
  // the one clock the block needs to see an edge, so slow sampling is still exercised honestly.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_in);
      mosi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      if (i < 8) rx = {rx[6:0], miso_in};
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // A released line has no pull, so it must not keep the last bit.
    mosi_out <= ~mosi_out;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the driver register bank with a reference model.
`timescale 1ns/1ps
module testbench;
  logic       clk_in   = 1'b0;
  logic       reset_in = 1'b1;
  logic       sclk, cs_n, mosi, miso;
  logic [4:0] on_cmd   = 5'h00;
  logic [4:0] sink_en  = 5'h00;
  logic [4:0] f_ol     = 5'h00;
  logic [4:0] f_oc     = 5'h00;
  logic [4:0] f_ot     = 5'h00;
  logic [4:0] f_sg     = 5'h00;
  logic [9:0] rate     = 10'h000;
  logic       spark    = 1'b0;
  logic       heater   = 1'b0;
  logic [4:0] gates;
  logic       spark_g, heater_g;
  logic [7:0] rx, v;
  logic [15:0] n [5];
  int         err_count = 0;
  int         compares  = 0;
  int         seed      = 39990;
  int         duty_m [8] = '{default: 0};
  int         sa [5] = '{0, 2, 3, 4, 5};
  int         ca [5] = '{2, 4, 5, 6, 7};
  int         tr [8] = '{1, 1, 1, 1, 0, 3, 2, 2};
  int         td [8] = '{0, 37, 100, 127, 5, 5, 0, 127};
  int         mn, ex;

  always #5 clk_in = ~clk_in;

  lsd_regs #(.SLOW_STEP_CYC(20)) i_lsd_regs (
    .clk_in(clk_in), .reset_in(reset_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .drv_on_cmd_in(on_cmd), .pwm_rate_sel_in(rate),
    .ol_sink_en_in(sink_en), .open_load_in(f_ol), .overcurrent_in(f_oc),
    .overtemp_in(f_ot), .short_gnd_in(f_sg), .spark_parallel_in(spark),
    .heater_parallel_in(heater), .driver_gate_out(gates),
    .spark_gate_out(spark_g), .heater_gate_out(heater_g)
  );

  lsd_spi_host i_lsd_spi_host (
    .clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso)
  );

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic bank, input int a);
    i_lsd_spi_host.xfer({1'b0, bank, 6'(a), 8'h00}, rx);
  endtask

  task automatic wr(input logic bank, input int a, input logic [7:0] d);
    i_lsd_spi_host.xfer({1'b1, bank, 6'(a), d}, rx);
  endtask

  // Open load is masked by its sink enable; the tach has no ground short.
  function automatic logic [7:0] flt(input int d);
    logic [3:0] low;
    low = {f_ol[d] & sink_en[d], f_oc[d], f_ot[d], (d != 3) & f_sg[d]};
    return {|low, 3'h0, low};
  endfunction

  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int d = 0; d < 5; d++) begin
      rd(1'b1, sa[d]);
      cmp_reg(rx, 8'h00);
      rd(1'b0, ca[d]);
      cmp_reg(rx, 8'h00);
    end
    rd(1'b1, 1);
    cmp_reg(rx, 8'h00);
    rd(1'b1, 14);
    cmp_reg(rx, 8'h00);
    $display("reset values test done");
    for (int a = 2; a < 8; a++) begin
      v = 8'($random(seed));
      wr(1'b0, a, v);
      if (a != 3) duty_m[a] = int'(v[6:0]);
      wr(1'b1, a, 8'hFF);
      rd(1'b0, a);
      cmp_reg(rx, 8'(duty_m[a]));
    end
    $display("duty register test done");
    repeat (8) begin
      @(posedge clk_in);
      f_ol <= 5'($random(seed));
      f_oc <= 5'($random(seed));
      f_ot <= 5'($random(seed));
      f_sg <= 5'($random(seed));
      sink_en <= 5'($random(seed));
      repeat (3) @(posedge clk_in);
      for (int d = 0; d < 5; d++) begin
        rd(1'b1, sa[d]);
        cmp_reg(rx, flt(d));
      end
    end
    $display("fault status test done");
    repeat (4) begin
      @(posedge clk_in);
      on_cmd <= 5'($random(seed));
      spark <= 1'($random(seed));
      heater <= 1'($random(seed));
      repeat (4) @(posedge clk_in);
      cmp_reg({7'h00, spark_g}, {7'h00, spark});
      cmp_reg({7'h00, heater_g}, {7'h00, heater});
      rd(1'b1, 14);
      cmp_reg(rx, {on_cmd[0], 1'b0, on_cmd[1], on_cmd[2], on_cmd[4],
                   spark, 1'b0, heater});
    end
    $display("indicator test done");
    @(posedge clk_in);
    on_cmd <= 5'h1F;
    for (int k = 0; k < 8; k++) begin
      for (int d = 0; d < 5; d++) begin
        wr(1'b0, ca[d], 8'(td[k]));
      end
      rate <= {5{2'(tr[k])}};
      repeat (10) @(posedge clk_in);
      n = '{default: 16'h0000};
      repeat (2000) begin
        @(posedge clk_in);
        for (int d = 0; d < 5; d++) begin
          if (gates[d] === 1'b1) n[d]++;
        end
      end
      mn = (td[k] > 100) ? 100 : td[k];
      ex = (tr[k] == 1 || tr[k] == 2) ? mn * 20 : 2000;
      for (int d = 0; d < 5; d++) begin
        cmp_cnt(n[d], 16'(ex));
      end
    end
    $display("modulation test done");
    conclude();
  end
endmodule
